// [design/ptw_map.vh]
// Constants shared by the peripheral timers and the system guard timer
//------------------------------------------------------------------
// Overview of operation
// R1 - Four independent timers, own setup, own interrupt
// R2 - 32-bit counter, free-running or user-defined count
// R3 - User mode counts down loaded value, interrupts at zero
// R4 - Timer interrupt held in flop, visible without bus clock
// R5 - Guard option one: timeout requests system reset
// R6 - Option two: interrupt first, reset if still uncleared
// R7 - Software clears guard interrupt before second timeout
// R8 - Guard interrupt output goes to interrupt distributor
// R9 - Reset request goes to system control block
// R10 - Guard timer has its own reset input
// R11 - Cores and control processor both reach controls
// R12 - Free-running counts down from maximum and wraps
//------------------------------------------------------------------
`ifndef PTW_MAP_VH
`define PTW_MAP_VH

`define PTW_NUM_TIMERS   4
`define PTW_CNT_W        32
`define PTW_CNT_MAX      32'hffffffff
`define PTW_CNT_ZERO     32'h00000000
`define PTW_MODE_FREE    1'b0
`define PTW_MODE_USER    1'b1

`define PTW_GS_IDLE      2'h0
`define PTW_GS_RUN       2'h1
`define PTW_GS_WARN      2'h2
`define PTW_GS_FIRED     2'h3

`endif

// [design/ptw_guard.v]
// System guard timer: timeout counter with one- or two-stage action
`timescale 1ns/10ps
`default_nettype none
`include "ptw_map.vh"

module ptw_guard #(
  parameter CNT_W = `PTW_CNT_W
) (
  input  wire             mclk,
  input  wire             guardRst,
  input  wire             guardEnable,
  input  wire             guardTwoStage,
  input  wire             guardKick,
  input  wire             guardIrqClear,
  input  wire [CNT_W-1:0] guardLoadValue,
  output reg              guardIrq,
  output reg              guardResetReq,
  output reg  [1:0]       guardState,
  output reg  [CNT_W-1:0] guardCount
);

  localparam [CNT_W-1:0] ZERO = {CNT_W{1'b0}};
  localparam [CNT_W-1:0] ONE  = {{(CNT_W-1){1'b0}}, 1'b1};

  reg [1:0]       next_state;
  reg [CNT_W-1:0] next_count;
  reg             setIrq;

  //------------------------------------------------------------------
  // Sequencing
  //------------------------------------------------------------------
  always @* begin
    next_state = guardState;
    next_count = guardCount;
    setIrq     = 1'b0;
    case (guardState)
      `PTW_GS_IDLE: begin
        if (guardEnable) begin
          next_state = `PTW_GS_RUN;
          next_count = guardLoadValue;
        end
      end
      `PTW_GS_RUN: begin
        if (!guardEnable) begin
          next_state = `PTW_GS_IDLE;
        end else if (guardKick) begin
          next_count = guardLoadValue;
        end else if (guardCount == ZERO) begin
          if (guardTwoStage) begin
            next_state = `PTW_GS_WARN;                 // see R6
            next_count = guardLoadValue;
            setIrq     = 1'b1;
          end else begin
            next_state = `PTW_GS_FIRED;                // see R5
          end
        end else begin
          next_count = guardCount - ONE;
        end
      end
      `PTW_GS_WARN: begin
        if (!guardEnable) begin
          next_state = `PTW_GS_IDLE;
        end else if (guardKick) begin
          next_count = guardLoadValue;
        end else if (guardCount == ZERO) begin
          // Escalate only when software left the interrupt pending
          if (guardIrq && !guardIrqClear) begin
            next_state = `PTW_GS_FIRED;                // see R6, R7
          end else begin
            next_state = `PTW_GS_RUN;
            next_count = guardLoadValue;
          end
        end else begin
          next_count = guardCount - ONE;
        end
      end
      default: begin
        // Fired is left only through the guard's own reset
        next_state = `PTW_GS_FIRED;
      end
    endcase
  end

  //------------------------------------------------------------------
  // State, interrupt and reset request
  //------------------------------------------------------------------
  always @(posedge mclk) begin
    if (guardRst) begin                                // see R10
      guardState    <= `PTW_GS_IDLE;
      guardCount    <= ZERO;
      guardIrq      <= 1'b0;
      guardResetReq <= 1'b0;
    end else begin
      guardState <= next_state;
      guardCount <= next_count;
      // Set wins over a clear landing in the same cycle
      if (setIrq) begin
        guardIrq <= 1'b1;                              // see R8
      end else if (guardIrqClear) begin
        guardIrq <= 1'b0;
      end
      guardResetReq <= (next_state == `PTW_GS_FIRED);  // see R9
    end
  end

endmodule // ptw_guard

`default_nettype wire

// [design/ptw_top.v]
// Four peripheral timers and the system guard timer of the slow peripheral group
`timescale 1ns/10ps
`default_nettype none
`include "ptw_map.vh"

module ptw_top #(
  parameter NUM_TIMERS = `PTW_NUM_TIMERS,
  parameter CNT_W      = `PTW_CNT_W
) (
  input  wire                        mclk,
  input  wire                        rst,
  input  wire [NUM_TIMERS-1:0]       timerEnable,
  input  wire [NUM_TIMERS-1:0]       timerModeUser,
  input  wire [NUM_TIMERS-1:0]       appLoad,
  input  wire [CNT_W-1:0]            appLoadValue,
  input  wire [NUM_TIMERS-1:0]       appIrqClear,
  input  wire [NUM_TIMERS-1:0]       cpLoad,
  input  wire [CNT_W-1:0]            cpLoadValue,
  input  wire [NUM_TIMERS-1:0]       cpIrqClear,
  output reg  [NUM_TIMERS*CNT_W-1:0] timerCount,
  output reg  [NUM_TIMERS-1:0]       timerIrq,
  input  wire                        guardRst,
  input  wire                        guardEnable,
  input  wire                        guardTwoStage,
  input  wire                        guardKick,
  input  wire                        guardIrqClear,
  input  wire [CNT_W-1:0]            guardLoadValue,
  output wire                        guardIrq,
  output wire                        guardResetReq,
  output wire [1:0]                  guardState,
  output wire [CNT_W-1:0]            guardCount
);

  localparam [CNT_W-1:0] ZERO = `PTW_CNT_ZERO;
  localparam [CNT_W-1:0] MAXV = `PTW_CNT_MAX;
  localparam [CNT_W-1:0] ONE  = {{(CNT_W-1){1'b0}}, 1'b1};

  // One down-count step in either mode
  function [CNT_W-1:0] step;
    input [CNT_W-1:0] cur;
    input             userMode;
    begin
      if (cur != ZERO) begin
        step = cur - ONE;
      end else if (userMode == `PTW_MODE_USER) begin
        step = ZERO;
      end else begin
        step = MAXV;
      end
    end
  endfunction

  reg [NUM_TIMERS*CNT_W-1:0] next_count;
  reg [NUM_TIMERS-1:0]       next_irq;
  reg [CNT_W-1:0]            cur;
  reg                        loadAny;
  reg [CNT_W-1:0]            loadVal;
  integer                    i;

  //------------------------------------------------------------------
  // Timer channels
  //------------------------------------------------------------------
  always @* begin
    next_count = timerCount;
    next_irq   = timerIrq;
    cur        = ZERO;
    loadAny    = 1'b0;
    loadVal    = ZERO;
    for (i = 0; i < NUM_TIMERS; i = i + 1) begin   // see R1
      cur     = timerCount[i*CNT_W +: CNT_W];
      // Either master may load; the control processor wins a tie
      loadAny = appLoad[i] | cpLoad[i];            // see R11
      loadVal = cpLoad[i] ? cpLoadValue : appLoadValue;
      if (appIrqClear[i] | cpIrqClear[i]) begin    // see R11
        next_irq[i] = 1'b0;
      end
      if (loadAny) begin
        if (timerModeUser[i] == `PTW_MODE_USER) begin
          next_count[i*CNT_W +: CNT_W] = loadVal;  // see R2, R3
        end else begin
          next_count[i*CNT_W +: CNT_W] = MAXV;     // see R12
        end
      end else if (timerEnable[i]) begin
        next_count[i*CNT_W +: CNT_W] = step(cur, timerModeUser[i]);  // see R2, R12
        // Interrupt fires once, on arrival at zero; set beats clear
        if (timerModeUser[i] == `PTW_MODE_USER && cur == ONE) begin
          next_irq[i] = 1'b1;                      // see R3
        end
      end
    end
  end

  // Interrupt is a held level on the free-running timer clock, so the
  // receiver still sees it while the bus clock is stopped.
  always @(posedge mclk) begin
    if (rst) begin
      timerCount <= {NUM_TIMERS*CNT_W{1'b0}};
      timerIrq   <= {NUM_TIMERS{1'b0}};
    end else begin
      timerCount <= next_count;
      timerIrq   <= next_irq;                      // see R4
    end
  end

  //------------------------------------------------------------------
  // System guard timer
  //------------------------------------------------------------------
  ptw_guard #(
    .CNT_W          (CNT_W)
  ) uGuard (
    .mclk           (mclk),
    .guardRst       (guardRst),
    .guardEnable    (guardEnable),
    .guardTwoStage  (guardTwoStage),
    .guardKick      (guardKick),
    .guardIrqClear  (guardIrqClear),
    .guardLoadValue (guardLoadValue),
    .guardIrq       (guardIrq),
    .guardResetReq  (guardResetReq),
    .guardState     (guardState),
    .guardCount     (guardCount)
  );

endmodule // ptw_top

`default_nettype wire

// [sim/ptw_top_properties.sv]
// Port relation checker for the timers and the system guard timer
`timescale 1ns/10ps
`default_nettype none
module ptw_top_properties #(
  parameter NUM_TIMERS = 4,
  parameter CNT_W      = 32
) (
  input wire logic                        mclk,
  input wire logic                        rst,
  input wire logic [NUM_TIMERS-1:0]       timerEnable,
  input wire logic [NUM_TIMERS-1:0]       timerModeUser,
  input wire logic [NUM_TIMERS-1:0]       appLoad,
  input wire logic [NUM_TIMERS-1:0]       cpLoad,
  input wire logic [CNT_W-1:0]            cpLoadValue,
  input wire logic [NUM_TIMERS*CNT_W-1:0] timerCount,
  input wire logic [NUM_TIMERS-1:0]       timerIrq,
  input wire logic                        guardRst,
  input wire logic                        guardEnable,
  input wire logic                        guardTwoStage,
  input wire logic                        guardKick,
  input wire logic                        guardIrqClear,
  input wire logic [CNT_W-1:0]            guardLoadValue,
  input wire logic                        guardIrq,
  input wire logic                        guardResetReq,
  input wire logic [1:0]                  guardState,
  input wire logic [CNT_W-1:0]            guardCount
);
  // Only timer 0 is watched; the others share the same logic
  wire [31:0] cnt0 = timerCount[31:0];
  wire        run0 = timerEnable[0] && !appLoad[0] && !cpLoad[0];
  wire        gRun = guardEnable && !guardKick && guardCount == 32'h0;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst || guardRst);
  //----------------------------------------------------------------
  // Timer and guard relations
  //----------------------------------------------------------------
  a_user_decrement: assert property (timerModeUser[0] && run0 && cnt0 > 32'h1 |=>
    cnt0 == $past(cnt0) - 32'h1) else $error("user count did not step down");
  a_user_zero_irq: assert property (timerModeUser[0] && run0 && cnt0 == 32'h1 |=>
    cnt0 == 32'h0 && timerIrq[0]) else $error("no interrupt at zero");
  a_free_wrap: assert property (!timerModeUser[0] && run0 && cnt0 == 32'h0 |=>
    cnt0 == 32'hffffffff) else $error("free count did not wrap");
  a_free_quiet: assert property (!timerModeUser[0] && !timerIrq[0] |=> !timerIrq[0])
    else $error("free mode raised an interrupt");
  a_disabled_hold: assert property (!timerEnable[0] && !appLoad[0] && !cpLoad[0]
    |=> $stable(cnt0)) else $error("disabled timer moved");
  a_cp_load_wins: assert property (cpLoad[0] && timerModeUser[0] |=>
    cnt0 == $past(cpLoadValue)) else $error("control processor load lost");
  a_guard_single: assert property (guardState == 2'h1 && gRun && !guardTwoStage |=>
    guardResetReq && guardState == 2'h3) else $error("single stage did not fire");
  a_guard_warn: assert property (guardState == 2'h1 && gRun && guardTwoStage |=>
    guardIrq && guardState == 2'h2 && guardCount == $past(guardLoadValue))
    else $error("first timeout did not warn");
  a_guard_escalate: assert property (guardState == 2'h2 && gRun && guardIrq &&
    !guardIrqClear |=> guardResetReq) else $error("second timeout did not fire");
  a_reset_held: assert property (guardResetReq |=> guardResetReq)
    else $error("reset request dropped");
  c_timer_irq: cover property (timerIrq[0]);
  c_guard_warn: cover property (guardState == 2'h2 ##1 guardState == 2'h1);
  c_guard_two: cover property (guardResetReq && guardTwoStage);
  c_guard_kick: cover property (guardKick && guardState == 2'h1 ##1 guardCount == guardLoadValue);
endmodule // ptw_top_properties
bind ptw_top ptw_top_properties #(.NUM_TIMERS(NUM_TIMERS), .CNT_W(CNT_W)) chk (.mclk, .rst,
  .timerEnable, .timerModeUser, .appLoad, .cpLoad, .cpLoadValue, .timerCount, .timerIrq,
  .guardRst, .guardEnable, .guardTwoStage, .guardKick, .guardIrqClear, .guardLoadValue,
  .guardIrq, .guardResetReq, .guardState, .guardCount);
`default_nettype wire

// [sim/ptw_top_bench.sv]
// Self-checking bench for the timers and the system guard timer
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, w) begin checks++; if ((g) !== (w)) begin badCount++; \
  $display("mismatch at %0t: got %h want %h", $time, g, w); end end
module ptw_top_bench;
  logic        mclk, rst, guardRst, guardEnable, guardTwoStage, guardKick, guardIrqClear;
  logic [3:0]  timerEnable, timerModeUser, appLoad, appIrqClear, cpLoad, cpIrqClear, timerIrq;
  logic [31:0] appLoadValue, cpLoadValue, guardLoadValue, guardCount;
  logic [127:0] timerCount;
  logic        guardIrq, guardResetReq;
  logic [1:0]  guardState;
  int          badCount = 0;
  int          checks = 0;
  ptw_top uut (.mclk, .rst, .timerEnable, .timerModeUser, .appLoad, .appLoadValue,
    .appIrqClear, .cpLoad, .cpLoadValue, .cpIrqClear, .timerCount, .timerIrq, .guardRst,
    .guardEnable, .guardTwoStage, .guardKick, .guardIrqClear, .guardLoadValue, .guardIrq,
    .guardResetReq, .guardState, .guardCount);
  //----------------------------------------------------------------
  // Scenarios
  //----------------------------------------------------------------
  task step(input int n); repeat (n) @(negedge mclk); endtask
  task conclude;
    if (badCount == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Timer 3 gets both loads at once, so the tie shows in its shorter count
  task user_count;
    timerModeUser = 4'hf; timerEnable = 4'hf; appLoad = 4'hf; appLoadValue = 32'h5;
    cpLoad = 4'h8; cpLoadValue = 32'h2;
    step(1); appLoad = 4'h0; cpLoad = 4'h0;
    step(2);
    `CHK(timerIrq, 4'h8)
    `CHK(timerCount[31:0], 32'h3)
    `CHK(timerCount[96+:32], 32'h0)
    step(3);
    `CHK(timerIrq, 4'hf)
    appIrqClear = 4'h1; cpIrqClear = 4'h2;
    step(1); appIrqClear = 4'h0; cpIrqClear = 4'h0;
    `CHK(timerIrq, 4'hc)
  endtask
  task free_wrap;
    // Both masters load timer 0 in user mode; the control processor's value must land
    timerEnable = 4'h0; appLoad = 4'h1; appLoadValue = 32'h9;
    cpLoad = 4'h1; cpLoadValue = 32'h2;
    step(1); appLoad = 4'h0; cpLoad = 4'h0; timerModeUser = 4'h0;
    step(2);
    `CHK(timerCount[31:0], 32'h2)
    timerEnable = 4'h1;
    step(3);
    `CHK(timerCount[31:0], 32'hffffffff)
    `CHK(timerIrq, 4'hc)
    appLoad = 4'h1; appLoadValue = 32'h7;
    step(1); appLoad = 4'h0;
    `CHK(timerCount[31:0], 32'hffffffff)
  endtask
  task guard_single;
    guardLoadValue = 32'h2; guardEnable = 1'b1;
    step(3);
    `CHK(guardResetReq, 1'b0)
    step(1);
    `CHK({guardState, guardResetReq}, 3'h7)
    rst = 1'b1;
    step(1); rst = 1'b0;
    `CHK(guardResetReq, 1'b1)
    `CHK(timerCount, 128'h0)
    guardRst = 1'b1;
    step(1); guardRst = 1'b0;
    `CHK({guardState, guardResetReq}, 3'h0)
  endtask
  // Clearing the warning once restarts the run; the second warning escalates
  task guard_two;
    guardTwoStage = 1'b1;
    step(4);
    `CHK({guardState, guardIrq, guardCount}, {2'h2, 1'b1, 32'h2})
    guardIrqClear = 1'b1;
    step(1); guardIrqClear = 1'b0;
    step(2);
    `CHK({guardState, guardResetReq}, 3'h2)
    step(6);
    `CHK({guardState, guardResetReq}, 3'h7)
  endtask
  // A kick in run restarts the timeout; dropping enable returns to idle
  task guard_kick;
    guardRst = 1'b1; guardTwoStage = 1'b0;
    step(1); guardRst = 1'b0;
    step(2); guardKick = 1'b1;
    step(1); guardKick = 1'b0;
    `CHK(guardCount, 32'h2)
    step(2);
    `CHK({guardState, guardResetReq}, 3'h2)
    guardEnable = 1'b0;
    step(1);
    `CHK({guardState, guardResetReq}, 3'h0)
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    repeat (2000) @(posedge mclk);
    badCount++;
    conclude();
  end
  initial begin
    {rst, guardRst, guardEnable, guardTwoStage, guardKick, guardIrqClear} = 6'h30;
    {timerEnable, timerModeUser, appLoad, appIrqClear, cpLoad, cpIrqClear} = 24'h0;
    {appLoadValue, cpLoadValue, guardLoadValue} = 96'h0;
    step(10); rst = 1'b0; guardRst = 1'b0;
    user_count();
    free_wrap();
    guard_single();
    guard_two();
    guard_kick();
    conclude();
  end
endmodule // ptw_top_bench
`undef CHK
`default_nettype wire
